// ===== bench/hie_event_props.sv
// Port-level assertions for the interrupt event register
`timescale 1ns/10ps
`default_nettype none

module hie_event_props #(
  parameter LIMIT_CYC = 6250
) (
  input wire logic clk_in, // Controller clock
  input wire logic nrst_in, // Reset, active low
  input wire logic soft_rst_in, // Soft reset
  input wire logic [7:0] addr_in, // Register address
  input wire logic [31:0] wdata_in, // Write data
  input wire logic wr_in, // Write strobe
  input wire logic rd_in, // Read strobe
  input wire logic [31:0] rdata_out, // Read data
  input wire logic bus_reinit_in, // Bus reset source
  input wire logic cs_tx_start_in, // Cycle start sent
  input wire logic subaction_gap_in, // Subaction gap ended
  input wire logic cycle_master_enable_out, // Master enable
  input wire logic flush_outbound_out, // Flush request
  input wire logic irq_out // Interrupt request
);
  logic armed;
  int cnt;

  // ****************************************
  // Watchdog shadow counter
  // ****************************************
  // Counts cycles since a cycle start while master, until a gap
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      armed <= 1'b0;
      cnt <= 0;
    end else begin
      if (!cycle_master_enable_out || subaction_gap_in) begin
        armed <= 1'b0;
      end else if (cs_tx_start_in) begin
        armed <= 1'b1;
      end
      cnt <= (armed && !cs_tx_start_in) ? cnt + 1 : 0;
    end
  end

  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);

  property p_rd_idle;
    !$past(rd_in) |-> rdata_out == 32'h0;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");

  property p_resv;
    $past(rd_in && addr_in == 8'h00) |-> (rdata_out & 32'hf804_fe00) == 32'h0;
  endproperty
  a_resv: assert property (p_resv) else $error("reserved bits set");

  property p_unmap;
    $past(rd_in && addr_in > 8'h20) |-> rdata_out == 32'h0;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");

  property p_set_rd;
    (wr_in && addr_in == 8'h00 && !soft_rst_in) ##2 (rd_in && addr_in == 8'h00)
      |=> (rdata_out & $past(wdata_in, 3) & 32'h07fb_013f)
        == ($past(wdata_in, 3) & 32'h07fb_013f);
  endproperty
  a_set_rd: assert property (p_set_rd) else $error("set alias lost bits");

  property p_flush_up;
    $rose(bus_reinit_in) && !soft_rst_in |-> ##[1:3] flush_outbound_out;
  endproperty
  a_flush_up: assert property (p_flush_up) else $error("no flush");

  property p_flush_dn;
    wr_in && addr_in == 8'h04 && wdata_in[17] && $stable(bus_reinit_in)
      |-> ##[1:3] !flush_outbound_out;
  endproperty
  a_flush_dn: assert property (p_flush_dn) else $error("flush stuck");

  property p_wd_bound;
    cnt <= LIMIT_CYC + 4;
  endproperty
  a_wd_bound: assert property (p_wd_bound) else $error("overrun missed");

  property p_wd_fall;
    $fell(cycle_master_enable_out) && !$past(soft_rst_in)
      |-> $past(cnt) >= LIMIT_CYC - 3;
  endproperty
  a_wd_fall: assert property (p_wd_fall) else $error("master dropped early");

  property p_soft_irq;
    soft_rst_in |=> ##1 !irq_out;
  endproperty
  a_soft_irq: assert property (p_soft_irq) else $error("irq after soft reset");
endmodule

bind hie_event_reg hie_event_props #(.LIMIT_CYC(LIMIT_CYC)) u_props (
  .clk_in(clk_in), .nrst_in(nrst_in), .soft_rst_in(soft_rst_in),
  .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
  .rdata_out(rdata_out), .bus_reinit_in(bus_reinit_in),
  .cs_tx_start_in(cs_tx_start_in), .subaction_gap_in(subaction_gap_in),
  .cycle_master_enable_out(cycle_master_enable_out),
  .flush_outbound_out(flush_outbound_out), .irq_out(irq_out));

`default_nettype wire

// ===== bench/hie_host_model.sv
// Host processor and driver model on the register port
`timescale 1ns/10ps
`default_nettype none

module hie_host_model (
  input wire logic clk_in, // Controller clock
  input wire logic [31:0] rdata_in, // Read data from block
  input wire logic outbound_idle_in, // Both outbound contexts idle
  output logic [7:0] addr_out, // Register address
  output logic [31:0] wdata_out, // Write data
  output logic wr_out, // Write strobe
  output logic rd_out // Read strobe
);
  // Bus idle from time zero
  initial begin
    addr_out = 8'h00;
    wdata_out = 32'h0;
    wr_out = 1'b0;
    rd_out = 1'b0;
  end

  // One-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    addr_out <= a;
    wdata_out <= d;
    wr_out <= 1'b1;
    @(posedge clk_in);
    wr_out <= 1'b0;
  endtask

  // One-cycle read strobe, data taken in the following cycle
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_in);
    addr_out <= a;
    rd_out <= 1'b1;
    @(posedge clk_in);
    rd_out <= 1'b0;
    @(posedge clk_in);
    d = rdata_in;
  endtask

  // Clears the bus reset event only once outbound work has drained
  task automatic clear_reinit();
    wait (outbound_idle_in === 1'b1);
    wr(8'h04, 32'h0002_0000);
  endtask
endmodule

`default_nettype wire

// ===== bench/tb_host_interrupt_event_register.sv
// Self-checking bench for the interrupt event register
`timescale 1ns/10ps
`default_nettype none

module tb_host_interrupt_event_register;
  localparam int LIM = 20;
  logic clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic soft_rst = 1'b0;
  logic [31:0] src = 32'h0;
  logic cs_tx = 1'b0;
  logic gap = 1'b0;
  logic mset = 1'b0;
  logic ob_idle = 1'b0;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, rd_val;
  logic wr, rd, master, flush, irq;
  int bad_count = 0;
  int comparisons = 0;
  int cycles = 0;
  int bl [16] = '{0, 1, 2, 3, 4, 5, 8, 16, 17, 19, 20, 21, 22, 23, 24, 26};

  hie_host_model host (.clk_in(clk_in), .rdata_in(rdata),
    .outbound_idle_in(ob_idle), .addr_out(addr), .wdata_out(wdata),
    .wr_out(wr), .rd_out(rd));

  hie_event_reg #(.LIMIT_CYC(LIM)) uut (.clk_in(clk_in), .nrst_in(nrst_in),
    .soft_rst_in(soft_rst), .addr_in(addr), .wdata_in(wdata), .wr_in(wr),
    .rd_in(rd), .rdata_out(rdata), .out_request_done_in(src[0]),
    .out_response_done_in(src[1]), .in_request_desc_done_in(src[2]),
    .in_response_desc_done_in(src[3]), .in_request_packet_in(src[4]),
    .in_response_packet_in(src[5]), .deferred_write_fault_in(src[8]),
    .topology_scan_done_in(src[16]), .bus_reinit_in(src[17]),
    .phy_irq_in(src[19]), .cycle_count_lsb_in(src[20]),
    .seconds_bit7_in(src[21]), .missing_cycle_start_in(src[22]),
    .cycle_count_mismatch_in(src[23]), .fatal_fault_in(src[24]),
    .cs_tx_start_in(cs_tx), .subaction_gap_in(gap),
    .transceiver_reg_byte_ready_in(src[26]), .cycle_master_set_in(mset),
    .cycle_master_enable_out(master), .flush_outbound_out(flush),
    .irq_out(irq));

  // ****************************************
  // Checking and closing
  // ****************************************
  task automatic chk(input string nm, input logic [31:0] exp,
                     input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Read one register and compare
  task automatic rchk(input string nm, input logic [7:0] a,
                      input logic [31:0] exp);
    host.rd(a, rd_val);
    chk(nm, exp, rd_val);
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_basic();
    host.wr(8'h04, 32'hffff_ffff);
    rchk("event raw", 8'h00, 32'h0);
    rchk("unmapped", 8'h40, 32'h0);
    $display("t_basic done");
  endtask

  task automatic t_set_clear();
    host.wr(8'h00, 32'hffff_ffff);
    rchk("set alias", 8'h00, 32'h07fb_013f);
    host.wr(8'h04, 32'h0000_0005);
    rchk("clear alias", 8'h00, 32'h07fb_013a);
    host.wr(8'h08, 32'h8000_0002);
    rchk("masked read", 8'h04, 32'h0000_0002);
    rchk("mask read", 8'h0c, 32'h8000_0002);
    chk("irq on", 32'h1, {31'h0, irq});
    host.wr(8'h0c, 32'h8000_0000);
    repeat (2) @(posedge clk_in);
    #1 chk("irq off", 32'h0, {31'h0, irq});
    host.wr(8'h04, 32'hffff_ffff);
    $display("t_set_clear done");
  endtask

  // Every source: edge sets, held level does not re-set, toggles count
  task automatic t_edges();
    int b;
    logic [31:0] m;
    foreach (bl[k]) begin
      b = bl[k];
      m = 32'h1 << b;
      @(posedge clk_in);
      src[b] <= 1'b1;
      repeat (3) @(posedge clk_in);
      rchk("edge set", 8'h00, m);
      host.wr(8'h04, m);
      rchk("held level", 8'h00, 32'h0);
      @(posedge clk_in);
      src[b] <= 1'b0;
      repeat (3) @(posedge clk_in);
      rchk("drop", 8'h00, (b == 20 || b == 21) ? m : 32'h0);
      host.wr(8'h04, 32'hffff_ffff);
    end
    $display("t_edges done");
  endtask

  task automatic t_fatal();
    @(posedge clk_in);
    src[24] <= 1'b1;
    repeat (3) @(posedge clk_in);
    src[0] <= 1'b1;
    repeat (3) @(posedge clk_in);
    rchk("ctx blocked", 8'h00, 32'h0100_0000);
    host.wr(8'h00, 32'h0000_0001);
    rchk("sw set", 8'h00, 32'h0100_0001);
    @(posedge clk_in);
    src[0] <= 1'b0;
    src[24] <= 1'b0;
    host.wr(8'h04, 32'hffff_ffff);
    $display("t_fatal done");
  endtask

  task automatic t_iso();
    host.wr(8'h10, 32'h0000_0004);
    host.wr(8'h14, 32'h0000_0004);
    host.wr(8'h18, 32'h0000_0100);
    rchk("iso out only", 8'h00, 32'h0000_0040);
    rchk("iso mask", 8'h14, 32'h0000_0004);
    host.wr(8'h1c, 32'h0000_0100);
    host.wr(8'h04, 32'h0000_00c0);
    rchk("iso both", 8'h00, 32'h0000_00c0);
    host.wr(8'h14, 32'h0);
    host.wr(8'h1c, 32'h0);
    rchk("iso none", 8'h00, 32'h0);
    $display("t_iso done");
  endtask

  // Bus reset edge racing a clear, then the drain handshake
  task automatic t_reinit();
    fork
      host.wr(8'h04, 32'h0002_0000);
      begin
        @(posedge clk_in);
        src[17] <= 1'b1;
      end
    join
    repeat (2) @(posedge clk_in);
    rchk("set beats clear", 8'h00, 32'h0002_0000);
    chk("flushing", 32'h1, {31'h0, flush});
    rchk("status flush", 8'h20, 32'h0000_0002);
    fork
      host.clear_reinit();
      begin
        repeat (4) @(posedge clk_in);
        ob_idle <= 1'b1;
        #1 chk("still flushing", 32'h1, {31'h0, flush});
      end
    join
    repeat (3) @(posedge clk_in);
    src[17] <= 1'b0;
    ob_idle <= 1'b0;
    #1 chk("flush stopped", 32'h0, {31'h0, flush});
    $display("t_reinit done");
  endtask

  task automatic t_watchdog();
    @(posedge clk_in);
    mset <= 1'b1;
    @(posedge clk_in);
    mset <= 1'b0;
    cs_tx <= 1'b1;
    @(posedge clk_in);
    cs_tx <= 1'b0;
    repeat (LIM / 2) @(posedge clk_in);
    gap <= 1'b1;
    @(posedge clk_in);
    gap <= 1'b0;
    repeat (LIM + 5) @(posedge clk_in);
    #1 chk("master kept", 32'h1, {31'h0, master});
    rchk("status master", 8'h20, 32'h0000_0001);
    @(posedge clk_in);
    cs_tx <= 1'b1;
    @(posedge clk_in);
    cs_tx <= 1'b0;
    repeat (LIM + 5) @(posedge clk_in);
    #1 chk("master dropped", 32'h0, {31'h0, master});
    host.wr(8'h08, 32'h8200_0000);
    rchk("overlong", 8'h00, 32'h0200_0000);
    chk("irq overlong", 32'h1, {31'h0, irq});
    @(posedge clk_in);
    soft_rst <= 1'b1;
    @(posedge clk_in);
    soft_rst <= 1'b0;
    rchk("soft reset", 8'h00, 32'h0);
    chk("irq soft reset", 32'h0, {31'h0, irq});
    $display("t_watchdog done");
  endtask

  // ****************************************
  // Clock, timeout and main sequence
  // ****************************************
  always #10 clk_in = ~clk_in;

  // Hang guard
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      stop_test();
    end
  end

  initial begin
    repeat (16) @(posedge clk_in);
    nrst_in <= 1'b1;
    t_basic();
    t_set_clear();
    t_edges();
    t_fatal();
    t_iso();
    t_reinit();
    t_watchdog();
    stop_test();
  end
endmodule

`default_nettype wire

// ===== hdl/hie_cycle_watch.v
// Overlong cycle watchdog for cycle master operation
`timescale 1ns/10ps
`default_nettype none
`include "hie_map.vh"

module hie_cycle_watch #(
  parameter LIMIT_CYC = `HIE_CYCLE_LIMIT_US * `HIE_CLK_MHZ
) (
  input wire clk_in, // Controller clock
  input wire nrst_in, // Asynchronous reset, active low
  input wire master_in, // Cycle master enabled
  input wire cs_tx_start_in, // Cycle start transmission begins
  input wire subaction_gap_in, // Subaction gap ended
  output reg overlong_out // One-cycle overrun pulse
);

  reg [15:0] count;
  reg running;

  // ****************************************
  // Count from cycle start to gap end
  // ****************************************
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      count <= 16'h0000;
      running <= 1'b0;
      overlong_out <= 1'b0;
    end else begin
      overlong_out <= 1'b0;
      if (!master_in) begin
        running <= 1'b0;
      end else if (cs_tx_start_in) begin
        running <= 1'b1;
        count <= 16'h0000;
      end else if (running && subaction_gap_in) begin
        running <= 1'b0;
      end else if (running) begin
        if (count >= LIMIT_CYC[15:0]) begin
          overlong_out <= 1'b1;
          running <= 1'b0;
        end else begin
          count <= count + 16'h0001;
        end
      end
    end
  end

endmodule
`default_nettype wire

// ===== hdl/hie_edge_det.v
// Rising edge detector for a vector of event sources
`timescale 1ns/10ps
`default_nettype none

module hie_edge_det #(
  parameter WIDTH = 32
) (
  input wire clk_in, // Controller clock
  input wire nrst_in, // Asynchronous reset, active low
  input wire [WIDTH-1:0] level_in, // Source levels
  output wire [WIDTH-1:0] rise_out // One-cycle rising pulses
);

  reg [WIDTH-1:0] prev;

  // ****************************************
  // Previous level store
  // ****************************************
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      prev <= {WIDTH{1'b0}};
    end else begin
      prev <= level_in;
    end
  end

  // Pulse only on the asserting edge
  assign rise_out = level_in & ~prev;

endmodule
`default_nettype wire

// ===== hdl/hie_event_reg.v
// Primary interrupt event register with set and clear aliases
`timescale 1ns/10ps
`default_nettype none
`include "hie_map.vh"

// Contract
// - Event bits set on rising source edges
// - Set alias writes set bits written one
// - Clear alias writes clear bits written one
// - Set alias reads raw; clear alias masked
// - Event bits undefined after reset (cleared to zero here)
// - Bits 0,1: outbound request/response done
// - Bits 2,3: inbound descriptor completion
// - Bits 4,5: inbound packet placed
// - Bits 6,7: unlatched iso summaries
// - Bit 8: deferred write host fault
// - Bit 16: topology scan done
// - Bit 17: bus reinit entered
// - Bit 19: transceiver status interrupt
// - Bit 20: cycle count LSB toggle
// - Bit 21: seconds counter bit seven change
// - Bit 22: missing cycle start
// - Bit 23: received cycle count mismatch
// - Bit 24: fatal fault blocks context events
// - Bit 25 overlong cycle clears master
// - Bit 26: transceiver register byte ready
// - Flush outbound FIFOs while bit 17
// - Irq needs global enable and match
module hie_event_reg #(
  parameter ISO_OUT_N = 32,
  parameter ISO_IN_N = 32,
  parameter LIMIT_CYC = `HIE_CYCLE_LIMIT_US * `HIE_CLK_MHZ
) (
  input wire clk_in, // Controller clock
  input wire nrst_in, // Asynchronous reset, active low
  input wire soft_rst_in, // Soft reset
  input wire [`HIE_ADDR_W-1:0] addr_in, // Register address
  input wire [31:0] wdata_in, // Write data
  input wire wr_in, // Write strobe
  input wire rd_in, // Read strobe
  output reg [31:0] rdata_out, // Read data, cycle after strobe
  input wire out_request_done_in, // Outbound request command done
  input wire out_response_done_in, // Outbound response command done
  input wire in_request_desc_done_in, // Inbound request descr done
  input wire in_response_desc_done_in, // Inbound response descr done
  input wire in_request_packet_in, // Packet to inbound request buf
  input wire in_response_packet_in, // Packet to inbound response buf
  input wire deferred_write_fault_in, // Host fault on posted write
  input wire topology_scan_done_in, // Self-ident stream received
  input wire bus_reinit_in, // Transceiver in bus reset
  input wire phy_irq_in, // Transceiver status interrupt
  input wire cycle_count_lsb_in, // Cycle count low bit
  input wire seconds_bit7_in, // Cycle seconds bit seven
  input wire missing_cycle_start_in, // Missing cycle start detected
  input wire cycle_count_mismatch_in, // Received count differs
  input wire fatal_fault_in, // Subunit stopped by error
  input wire cs_tx_start_in, // Cycle start transmission begins
  input wire subaction_gap_in, // Subaction gap ended
  input wire transceiver_reg_byte_ready_in, // Transceiver reg byte
  input wire cycle_master_set_in, // Request cycle master enable
  output reg cycle_master_enable_out, // Cycle master enable
  output reg flush_outbound_out, // Flush outbound async FIFOs
  output reg irq_out // Processor interrupt request
);

  // ****************************************
  // Storage
  // ****************************************
  reg [31:0] interrupt_event;
  reg [31:0] interrupt_enable_mask;
  reg [ISO_OUT_N-1:0] iso_out_context_events;
  reg [ISO_OUT_N-1:0] iso_out_context_mask;
  reg [ISO_IN_N-1:0] iso_in_context_events;
  reg [ISO_IN_N-1:0] iso_in_context_mask;
  reg [31:0] next_event;
  reg [31:0] next_rdata;
  reg [31:0] src_level;
  wire [31:0] irq_cand;
  wire [31:0] status_view;
  wire [31:0] src_rise;
  wire overlong;
  wire iso_out_summary;
  wire iso_in_summary;
  wire [31:0] event_view;
  wire [31:0] hw_set;
  wire wr_ev_set;
  wire wr_ev_clr;

  // Address match helper used by every write decode
  function hit;
    input [`HIE_ADDR_W-1:0] a;
    input [`HIE_ADDR_W-1:0] ofs;
    begin
      hit = (a == ofs);
    end
  endfunction

  // ****************************************
  // Source vector, positioned as the event bits
  // ****************************************
  always @* begin
    src_level = 32'h00000000;
    src_level[`HIE_B_OUT_REQ] = out_request_done_in;
    src_level[`HIE_B_OUT_RSP] = out_response_done_in;
    src_level[`HIE_B_IN_REQ_DESC] = in_request_desc_done_in;
    src_level[`HIE_B_IN_RSP_DESC] = in_response_desc_done_in;
    src_level[`HIE_B_IN_REQ_PKT] = in_request_packet_in;
    src_level[`HIE_B_IN_RSP_PKT] = in_response_packet_in;
    src_level[`HIE_B_DEFER_FAULT] = deferred_write_fault_in;
    src_level[`HIE_B_TOPO_DONE] = topology_scan_done_in;
    src_level[`HIE_B_BUS_REINIT] = bus_reinit_in;
    src_level[`HIE_B_PHY_IRQ] = phy_irq_in;
    src_level[`HIE_B_MISSING_CS] = missing_cycle_start_in;
    src_level[`HIE_B_COUNT_MISM] = cycle_count_mismatch_in;
    src_level[`HIE_B_FATAL] = fatal_fault_in;
    src_level[`HIE_B_PHY_REG] = transceiver_reg_byte_ready_in;
  end

  // One edge detector covers every source except the two cycle timer bits
  hie_edge_det #(
    .WIDTH(32)
  ) u_edge (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .level_in(src_level),
    .rise_out(src_rise)
  );

  // Watchdog for the cycle master time limit
  hie_cycle_watch #(
    .LIMIT_CYC(LIMIT_CYC)
  ) u_watch (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .master_in(cycle_master_enable_out),
    .cs_tx_start_in(cs_tx_start_in),
    .subaction_gap_in(subaction_gap_in),
    .overlong_out(overlong)
  );

  // ****************************************
  // Cycle timer toggle detection
  // ****************************************
  // Last samples of the cycle timer bits
  reg lsb_prev;
  reg sec7_prev;
  wire new_cycle;
  wire sixty_four_second_tick;

  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      lsb_prev <= 1'b0;
      sec7_prev <= 1'b0;
    end else begin
      lsb_prev <= cycle_count_lsb_in;
      sec7_prev <= seconds_bit7_in;
    end
  end

  assign new_cycle = cycle_count_lsb_in ^ lsb_prev;
  assign sixty_four_second_tick = seconds_bit7_in ^ sec7_prev;

  // ****************************************
  // Hardware set vector
  // ****************************************
  // Toggle events and the fatal hold-off
  reg [31:0] toggles;
  wire [31:0] ctx_block;
  always @* begin
    toggles = 32'h00000000;
    toggles[`HIE_B_NEW_CYCLE] = new_cycle;
    toggles[`HIE_B_SIXTY_FOUR] = sixty_four_second_tick;
    toggles[`HIE_B_OVERLONG] = overlong;
  end
  // Context events held off while the fatal fault event bit is set
  assign ctx_block = interrupt_event[`HIE_B_FATAL] ?
    `HIE_CTX_BITS : 32'h00000000;
  // Only latched positions may be set by hardware
  assign hw_set = ((src_rise & ~ctx_block) | toggles) &
    `HIE_LATCH_MASK;

  // ****************************************
  // Isochronous summaries, never latched
  // ****************************************
  assign iso_out_summary =
    |(iso_out_context_events & iso_out_context_mask);
  assign iso_in_summary =
    |(iso_in_context_events & iso_in_context_mask);
  // Read view merges latched and summary bits
  assign event_view = (interrupt_event & `HIE_LATCH_MASK) |
    ({31'h0, iso_out_summary} << `HIE_B_ISO_OUT) |
    ({31'h0, iso_in_summary} << `HIE_B_ISO_IN);

  // ****************************************
  // Write strobes of the two event aliases
  // ****************************************
  assign wr_ev_set = wr_in && hit(addr_in, `HIE_OFS_EVENT_SET);
  assign wr_ev_clr = wr_in && hit(addr_in, `HIE_OFS_EVENT_CLR);

  // ****************************************
  // Next event value: software, then hardware
  // ****************************************
  always @* begin
    next_event = interrupt_event;
    if (wr_ev_set) begin
      next_event = next_event | (wdata_in & `HIE_LATCH_MASK);
    end
    if (wr_ev_clr) begin
      next_event = next_event & ~wdata_in;
    end
    next_event = next_event | hw_set;
  end

  // Event bits: reset value chosen as zero, software must clear anyway
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      interrupt_event <= 32'h00000000;
    end else if (soft_rst_in) begin
      interrupt_event <= 32'h00000000;
    end else begin
      interrupt_event <= next_event & `HIE_LATCH_MASK;
    end
  end

  // ****************************************
  // Mask and isochronous registers
  // ****************************************
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      interrupt_enable_mask <= 32'h00000000;
      iso_out_context_events <= {ISO_OUT_N{1'b0}};
      iso_out_context_mask <= {ISO_OUT_N{1'b0}};
      iso_in_context_events <= {ISO_IN_N{1'b0}};
      iso_in_context_mask <= {ISO_IN_N{1'b0}};
    end else if (soft_rst_in) begin
      interrupt_enable_mask <= 32'h00000000;
    end else if (wr_in) begin
      if (hit(addr_in, `HIE_OFS_MASK_SET)) begin
        interrupt_enable_mask <= interrupt_enable_mask |
          (wdata_in & `HIE_MASK_BITS);
      end
      if (hit(addr_in, `HIE_OFS_MASK_CLR)) begin
        interrupt_enable_mask <= interrupt_enable_mask & ~wdata_in;
      end
      // Isochronous registers take plain writes
      if (hit(addr_in, `HIE_OFS_ISO_OUT_EV)) begin
        iso_out_context_events <= wdata_in[ISO_OUT_N-1:0];
      end
      if (hit(addr_in, `HIE_OFS_ISO_OUT_MSK)) begin
        iso_out_context_mask <= wdata_in[ISO_OUT_N-1:0];
      end
      if (hit(addr_in, `HIE_OFS_ISO_IN_EV)) begin
        iso_in_context_events <= wdata_in[ISO_IN_N-1:0];
      end
      if (hit(addr_in, `HIE_OFS_ISO_IN_MSK)) begin
        iso_in_context_mask <= wdata_in[ISO_IN_N-1:0];
      end
    end
  end

  // ****************************************
  // Cycle master enable
  // ****************************************
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cycle_master_enable_out <= 1'b0;
    end else if (soft_rst_in || overlong) begin
      cycle_master_enable_out <= 1'b0;
    end else if (cycle_master_set_in) begin
      cycle_master_enable_out <= 1'b1;
    end
  end

  // ****************************************
  // Flush and interrupt outputs, registered
  // ****************************************
  // Flushing follows the bus reinit bit; soft reset ends it at once
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      flush_outbound_out <= 1'b0;
    end else if (soft_rst_in) begin
      flush_outbound_out <= 1'b0;
    end else begin
      flush_outbound_out <= next_event[`HIE_B_BUS_REINIT];
    end
  end

  // Request candidates leave out the global enable position
  assign irq_cand = event_view & interrupt_enable_mask &
    ~(32'h1 << `HIE_B_GLOBAL_EN);
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= interrupt_enable_mask[`HIE_B_GLOBAL_EN] &
        (|irq_cand);
    end
  end

  // ****************************************
  // Read mux
  // ****************************************
  // Status word: flush at bit 1, master enable at bit 0
  assign status_view = {30'h0, flush_outbound_out, cycle_master_enable_out};

  always @* begin
    next_rdata = 32'h00000000;
    case (addr_in)
      `HIE_OFS_EVENT_SET: next_rdata = event_view;
      `HIE_OFS_EVENT_CLR:
        next_rdata = event_view & interrupt_enable_mask;
      `HIE_OFS_MASK_SET: next_rdata = interrupt_enable_mask;
      `HIE_OFS_MASK_CLR: next_rdata = interrupt_enable_mask;
      `HIE_OFS_ISO_OUT_EV:
        next_rdata[ISO_OUT_N-1:0] = iso_out_context_events;
      `HIE_OFS_ISO_OUT_MSK:
        next_rdata[ISO_OUT_N-1:0] = iso_out_context_mask;
      `HIE_OFS_ISO_IN_EV:
        next_rdata[ISO_IN_N-1:0] = iso_in_context_events;
      `HIE_OFS_ISO_IN_MSK:
        next_rdata[ISO_IN_N-1:0] = iso_in_context_mask;
      `HIE_OFS_STATUS: next_rdata = status_view;
      default: next_rdata = 32'h00000000;
    endcase
  end

  // Read data valid only in the cycle after the strobe
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rdata_out <= 32'h00000000;
    end else if (rd_in) begin
      rdata_out <= next_rdata;
    end else begin
      rdata_out <= 32'h00000000;
    end
  end

endmodule
`default_nettype wire

// ===== inc/hie_map.vh
// Register map and bit positions of the interrupt event block
`ifndef HIE_MAP_VH
`define HIE_MAP_VH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define HIE_ADDR_W 8
`define HIE_OFS_EVENT_SET 8'h00
`define HIE_OFS_EVENT_CLR 8'h04
`define HIE_OFS_MASK_SET 8'h08
`define HIE_OFS_MASK_CLR 8'h0c
`define HIE_OFS_ISO_OUT_EV 8'h10
`define HIE_OFS_ISO_OUT_MSK 8'h14
`define HIE_OFS_ISO_IN_EV 8'h18
`define HIE_OFS_ISO_IN_MSK 8'h1c
`define HIE_OFS_STATUS 8'h20

// ****************************************
// Event bit positions
// ****************************************
`define HIE_B_OUT_REQ 0
`define HIE_B_OUT_RSP 1
`define HIE_B_IN_REQ_DESC 2
`define HIE_B_IN_RSP_DESC 3
`define HIE_B_IN_REQ_PKT 4
`define HIE_B_IN_RSP_PKT 5
`define HIE_B_ISO_OUT 6
`define HIE_B_ISO_IN 7
`define HIE_B_DEFER_FAULT 8
`define HIE_B_TOPO_DONE 16
`define HIE_B_BUS_REINIT 17
`define HIE_B_PHY_IRQ 19
`define HIE_B_NEW_CYCLE 20
`define HIE_B_SIXTY_FOUR 21
`define HIE_B_MISSING_CS 22
`define HIE_B_COUNT_MISM 23
`define HIE_B_FATAL 24
`define HIE_B_OVERLONG 25
`define HIE_B_PHY_REG 26
`define HIE_B_GLOBAL_EN 31
`define HIE_B_SECONDS_7 7

// Latched event bits: 0-5, 8, 16, 17, 19-26
`define HIE_LATCH_MASK 32'h07fb013f
// Bits that exist in the mask register
`define HIE_MASK_BITS 32'h87fb01ff
// Event bits whose hardware set a fatal fault blocks (per-context normal events)
`define HIE_CTX_BITS 32'h0000003f

// ****************************************
// Timing
// ****************************************
`define HIE_CLK_MHZ 50
`define HIE_CYCLE_LIMIT_US 125

`endif
